// File: logic/pipelined_burst_sram_port.v
// pipelined burst sram port: command pipeline, burst counter, sleep
`timescale 1ns/100ps
`include "sram_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module pipelined_burst_sram_port #(
	parameter ADDR_W = `ADDR_W_DEF,
	parameter LANES  = `LANES_DEF
) (
	// clock and reset
	input  wire                            clk_i,
	input  wire                            rst_n_i,
	// synchronous command pins
	input  wire                            clock_gate_n_i,
	input  wire                            chip_select_first_n_i,
	input  wire                            chip_select_second_i,
	input  wire                            chip_select_third_n_i,
	input  wire                            advance_or_load_i,
	input  wire                            write_n_i,
	input  wire [LANES-1:0]                lane_write_select_n_i,
	input  wire [ADDR_W-1:0]               addr_i,
	// asynchronous controls and strap
	input  wire                            output_drive_n_i,
	input  wire                            sleep_request_i,
	input  wire                            burst_order_i,
	// shared data lines
	input  wire [LANES*`LANE_DATA_BITS-1:0] dq_i,
	output wire [LANES*`LANE_DATA_BITS-1:0] dq_o,
	output wire [LANES*`LANE_DATA_BITS-1:0] dq_oe_o,
	// shared parity lines
	input  wire [LANES-1:0]                shared_parity_lines_i,
	output wire [LANES-1:0]                shared_parity_lines_o,
	output wire [LANES-1:0]                shared_parity_lines_oe_o,
	// status
	output wire                            sleep_status_o
);

	localparam DB = `LANE_DATA_BITS;
	localparam WB = `LANE_WORD_BITS;
	localparam [`SYNC_BITS-1:0] SYNC_RST = `SYNC_RST_VAL;

	////////////////////////////////////////////////////////////////////////
	// declarations

	wire [`SYNC_BITS-1:0]    filt;
	wire                     sleep_level;
	wire                     order_interleaved;

	reg  [`ST_W-1:0]         state_reg;
	reg  [`ST_W-1:0]         state_next;
	reg  [`SLEEP_CNT_W-1:0]  scnt_reg;
	reg  [`SLEEP_CNT_W-1:0]  scnt_next;
	wire                     running;
	wire                     op_en;

	wire                     cs_all;
	reg  [ADDR_W-1:0]        base_reg;
	reg  [`BEAT_W-1:0]       beat_reg;
	reg                      dir_write_reg;
	reg                      active_reg;
	reg                      order_reg;
	reg  [`BEAT_W-1:0]       beat_next;
	reg  [`BEAT_W-1:0]       seq_low;
	reg  [ADDR_W-1:0]        beat_addr;

	reg                      s1_valid_reg;
	reg                      s1_write_reg;
	reg  [ADDR_W-1:0]        s1_addr_reg;
	reg  [LANES-1:0]         s1_lane_n_reg;
	reg                      s2_valid_reg;
	reg  [ADDR_W-1:0]        s2_addr_reg;
	reg  [LANES-1:0]         s2_lane_n_reg;
	reg                      rd_drive_reg;

	wire                     mem_rd_en;
	wire                     mem_wr_en;
	wire [LANES*WB-1:0]      mem_rd_data;
	wire [LANES*WB-1:0]      mem_wr_data;
	wire                     drive;

	////////////////////////////////////////////////////////////////////////
	// three-stage synchronisers for the async sleep pin and order strap

	wire [`SYNC_BITS-1:0] sync_pin;
	assign sync_pin[`SYNC_SLEEP_BIT] = sleep_request_i;
	assign sync_pin[`SYNC_ORDER_BIT] = burst_order_i;

	genvar s;
	generate
		for (s = 0; s < `SYNC_BITS; s = s + 1)
		begin : g_sync
			reg [`SYNC_STAGES-1:0] chain_reg;
			reg                    level_reg;

			always @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					chain_reg <= {`SYNC_STAGES{SYNC_RST[s]}};
					level_reg <= SYNC_RST[s];
				end
				else
				begin
					chain_reg <= {chain_reg[`SYNC_STAGES-2:0], sync_pin[s]};
					// change counts once stages two and three agree
					if (chain_reg[1] == chain_reg[2])
						level_reg <= chain_reg[2];
				end
			end

			assign filt[s] = level_reg;
		end
	endgenerate

	assign sleep_level       = filt[`SYNC_SLEEP_BIT];
	assign order_interleaved = filt[`SYNC_ORDER_BIT];

	////////////////////////////////////////////////////////////////////////
	// sleep sequencer

	always @*
	begin
		state_next = state_reg;
		scnt_next  = scnt_reg;
		case (state_reg)
			`ST_RUN:
			begin
				if (sleep_level)
				begin
					state_next = `ST_ENTER;
					scnt_next  = `SLEEP_CNT_STEP;
				end
			end
			`ST_ENTER:
			begin
				// entry takes two cycles
				if (scnt_reg == `SLEEP_ENTRY_CYC)
					state_next = `ST_SLEEP;
				else
					scnt_next = scnt_reg + `SLEEP_CNT_STEP;
			end
			`ST_SLEEP:
			begin
				if (!sleep_level)
				begin
					state_next = `ST_RECOVER;
					scnt_next  = `SLEEP_CNT_STEP;
				end
			end
			`ST_RECOVER:
			begin
				// exit takes two cycles, commands ignored meanwhile
				if (sleep_level)
				begin
					state_next = `ST_ENTER;
					scnt_next  = `SLEEP_CNT_STEP;
				end
				else if (scnt_reg == `SLEEP_RECOVERY_CYC)
				begin
					state_next = `ST_RUN;
					scnt_next  = `SLEEP_CNT_ZERO;
				end
				else
					scnt_next = scnt_reg + `SLEEP_CNT_STEP;
			end
			default:
			begin
				state_next = `ST_RUN;
				scnt_next  = `SLEEP_CNT_ZERO;
			end
		endcase
	end

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_reg <= `ST_RUN;
			scnt_reg  <= `SLEEP_CNT_ZERO;
		end
		else
		begin
			state_reg <= state_next;
			scnt_reg  <= scnt_next;
		end
	end

	assign running        = (state_reg == `ST_RUN);
	assign sleep_status_o = (state_reg == `ST_SLEEP);
	// gate high: command logic ignores this edge; synchronisers and sleep sequencer still run
	assign op_en          = running & ~clock_gate_n_i;

	////////////////////////////////////////////////////////////////////////
	// burst counter and beat address

	assign cs_all = ~chip_select_first_n_i & chip_select_second_i &
		~chip_select_third_n_i;

	always @*
	begin
		// two-bit counter wraps inside the four-word group
		beat_next = beat_reg + `BEAT_STEP;
		if (order_reg == `ORDER_LINEAR)
			seq_low = base_reg[`BEAT_W-1:0] + beat_next;
		else
			seq_low = base_reg[`BEAT_W-1:0] ^ beat_next;
		beat_addr = {base_reg[ADDR_W-1:`BEAT_W], seq_low};
	end

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			base_reg      <= {ADDR_W{1'b0}};
			beat_reg      <= `BEAT_FIRST;
			dir_write_reg <= 1'b0;
			active_reg    <= 1'b0;
			order_reg     <= SYNC_RST[`SYNC_ORDER_BIT];
		end
		else if (!running)
			active_reg <= 1'b0;
		else if (op_en)
		begin
			if (advance_or_load_i)
				beat_reg <= beat_next;
			else
			begin
				base_reg      <= addr_i;
				beat_reg      <= `BEAT_FIRST;
				active_reg    <= cs_all;
				dir_write_reg <= ~write_n_i;
				order_reg     <= order_interleaved;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command pipeline: address stage, write data stage, read drive

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s1_valid_reg  <= 1'b0;
			s1_write_reg  <= 1'b0;
			s1_addr_reg   <= {ADDR_W{1'b0}};
			s1_lane_n_reg <= {LANES{1'b1}};
			s2_valid_reg  <= 1'b0;
			s2_addr_reg   <= {ADDR_W{1'b0}};
			s2_lane_n_reg <= {LANES{1'b1}};
			rd_drive_reg  <= 1'b0;
		end
		else if (!running)
		begin
			// pending accesses are dropped on sleep entry
			s1_valid_reg <= 1'b0;
			s2_valid_reg <= 1'b0;
			rd_drive_reg <= 1'b0;
		end
		else if (op_en)
		begin
			if (advance_or_load_i)
			begin
				s1_valid_reg <= active_reg;
				s1_write_reg <= dir_write_reg;
				s1_addr_reg  <= beat_addr;
			end
			else
			begin
				// any other command may follow the previous one
				s1_valid_reg <= cs_all;
				s1_write_reg <= ~write_n_i;
				s1_addr_reg  <= addr_i;
			end
			// lane selects are taken on every beat
			s1_lane_n_reg <= lane_write_select_n_i;
			s2_valid_reg  <= s1_valid_reg & s1_write_reg;
			s2_addr_reg   <= s1_addr_reg;
			s2_lane_n_reg <= s1_lane_n_reg;
			// write or deselect releases the bus after this edge
			rd_drive_reg  <= s1_valid_reg & ~s1_write_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// storage; its read register is the output register

	assign mem_rd_en = op_en & s1_valid_reg & ~s1_write_reg;
	assign mem_wr_en = op_en & s2_valid_reg;

	genvar l;
	generate
		for (l = 0; l < LANES; l = l + 1)
		begin : g_lane
			assign mem_wr_data[l*WB +: WB] =
				{shared_parity_lines_i[l], dq_i[l*DB +: DB]};
			assign dq_o[l*DB +: DB]         = mem_rd_data[l*WB +: DB];
			assign shared_parity_lines_o[l] = mem_rd_data[l*WB + DB];
		end
	endgenerate

	sram_lane_mem #(
		.ADDR_W (ADDR_W),
		.LANES  (LANES)
	) u_mem (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.rd_en_i   (mem_rd_en),
		.rd_addr_i (s1_addr_reg),
		.rd_data_o (mem_rd_data),
		.wr_en_i   (mem_wr_en),
		.wr_addr_i (s2_addr_reg),
		.wr_lane_i (~s2_lane_n_reg),
		.wr_data_i (mem_wr_data)
	);

	////////////////////////////////////////////////////////////////////////
	// output drive

	// async enable gates the registered read drive
	assign drive = rd_drive_reg & ~output_drive_n_i & running;

	assign dq_oe_o                  = {(LANES*DB){drive}};
	assign shared_parity_lines_oe_o = {LANES{drive}};

endmodule // pipelined_burst_sram_port

// File: logic/sram_defines.vh
// shared constants for the pipelined burst sram port
`ifndef SRAM_PORT_DEFINES_VH
`define SRAM_PORT_DEFINES_VH

// geometry defaults
`define ADDR_W_DEF          20
`define LANES_DEF           4
`define LANE_DATA_BITS      8
`define LANE_WORD_BITS      9

// burst counter
`define BEAT_W              2
`define BEAT_FIRST          2'h0
`define BEAT_STEP           2'h1
`define ORDER_LINEAR        1'b0

// input synchroniser: bit 0 sleep, bit 1 burst order
`define SYNC_BITS           2
`define SYNC_STAGES         3
`define SYNC_RST_VAL        2'h2
`define SYNC_SLEEP_BIT      0
`define SYNC_ORDER_BIT      1

// sleep entry and recovery, in clock cycles
`define SLEEP_CNT_W         2
`define SLEEP_ENTRY_CYC     2'h2
`define SLEEP_RECOVERY_CYC  2'h2
`define SLEEP_CNT_ZERO      2'h0
`define SLEEP_CNT_STEP      2'h1

// sleep state codes
`define ST_W                2
`define ST_RUN              2'h0
`define ST_ENTER            2'h1
`define ST_SLEEP            2'h2
`define ST_RECOVER          2'h3

`endif

// File: logic/sram_lane_mem.v
// lane-masked storage array with registered read port
`timescale 1ns/100ps
`include "sram_defines.vh"

module sram_lane_mem #(
	parameter ADDR_W = `ADDR_W_DEF,
	parameter LANES  = `LANES_DEF
) (
	// clock of both ports, reset of the read register
	input  wire                              clk_i,
	input  wire                              rst_n_i,
	// read port
	input  wire                              rd_en_i,
	input  wire [ADDR_W-1:0]                 rd_addr_i,
	output wire [LANES*`LANE_WORD_BITS-1:0]  rd_data_o,
	// write port, one enable per lane
	input  wire                              wr_en_i,
	input  wire [ADDR_W-1:0]                 wr_addr_i,
	input  wire [LANES-1:0]                  wr_lane_i,
	input  wire [LANES*`LANE_WORD_BITS-1:0]  wr_data_i
);

	localparam DEPTH = 1 << ADDR_W;
	localparam WB    = `LANE_WORD_BITS;

	genvar l;
	generate
		for (l = 0; l < LANES; l = l + 1)
		begin : g_lane
			reg [WB-1:0] store [0:DEPTH-1];
			reg [WB-1:0] rd_reg;

			// untouched lanes keep their contents
			always @(posedge clk_i)
			begin
				if (wr_en_i && wr_lane_i[l])
					store[wr_addr_i] <= wr_data_i[l*WB +: WB];
			end

			always @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					rd_reg <= {WB{1'b0}};
				else if (rd_en_i)
					rd_reg <= store[rd_addr_i];
			end

			assign rd_data_o[l*WB +: WB] = rd_reg;
		end
	endgenerate

endmodule // sram_lane_mem

// File: sim/pipelined_burst_sram_port_asserts.sv
// timing checks on the pins of the burst sram port
`timescale 1ns/100ps
`include "sram_defines.vh"
module pipelined_burst_sram_port_asserts #(
	parameter ADDR_W = `ADDR_W_DEF,
	parameter LANES  = `LANES_DEF
) (
	// clock and reset
	input wire                             clk_i,
	input wire                             rst_n_i,
	// command pins, output drive and sleep request
	input wire                             clock_gate_n_i,
	input wire                             chip_select_first_n_i,
	input wire                             chip_select_second_i,
	input wire                             chip_select_third_n_i,
	input wire                             advance_or_load_i,
	input wire                             write_n_i,
	input wire                             output_drive_n_i,
	input wire                             sleep_request_i,
	// outputs
	input wire [LANES*`LANE_DATA_BITS-1:0] dq_o,
	input wire [LANES*`LANE_DATA_BITS-1:0] dq_oe_o,
	input wire [LANES-1:0]                 shared_parity_lines_oe_o,
	input wire                             sleep_status_o
);
	wire sel = !chip_select_first_n_i && chip_select_second_i
		&& !chip_select_third_n_i;
	wire go = !clock_gate_n_i && !sleep_status_o;
	wire ld = go && !advance_or_load_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	gate_hold_a: assert property (
		clock_gate_n_i && !sleep_request_i && !sleep_status_o
		|=> $stable(dq_o)) else $error("dq moved on a gated edge");
	read_drive_a: assert property (
		(ld && sel && write_n_i) ##1 go |=> output_drive_n_i || &dq_oe_o)
		else $error("read data not driven");
	burst_keep_a: assert property (
		(ld && sel && write_n_i) ##1 (go && advance_or_load_i) ##1 go
		|=> output_drive_n_i || &dq_oe_o) else $error("read burst lost");
	write_float_a: assert property (
		(ld && sel && !write_n_i) ##1 go
		|=> dq_oe_o == '0 && shared_parity_lines_oe_o == '0)
		else $error("bus driven in write data phase");
	deselect_float_a: assert property (
		(ld && !sel) ##1 go |=> dq_oe_o == '0) else $error("bus held");
	oe_async_a: assert property (
		output_drive_n_i |-> dq_oe_o == '0) else $error("drive while oe off");
	oe_same_a: assert property (
		shared_parity_lines_oe_o == {LANES{dq_oe_o[0]}}
		&& (dq_oe_o == '0 || &dq_oe_o)) else $error("lane enables differ");
	sleep_float_a: assert property (
		sleep_status_o |-> dq_oe_o == '0) else $error("drive in sleep");
	sleep_enter_a: assert property (
		sleep_request_i [*8] |-> sleep_status_o) else $error("no sleep");
	sleep_leave_a: assert property (
		$fell(sleep_request_i) |-> ##[1:8] !sleep_status_o)
		else $error("no wake");
	reset_float_a: assert property (
		disable iff (1'b0) !rst_n_i |-> dq_oe_o == '0)
		else $error("drive in reset");
endmodule // pipelined_burst_sram_port_asserts
bind pipelined_burst_sram_port pipelined_burst_sram_port_asserts #(
	.ADDR_W(ADDR_W), .LANES(LANES)) u_asserts (.clk_i, .rst_n_i,
	.clock_gate_n_i, .chip_select_first_n_i, .chip_select_second_i,
	.chip_select_third_n_i, .advance_or_load_i, .write_n_i,
	.output_drive_n_i, .sleep_request_i, .dq_o, .dq_oe_o,
	.shared_parity_lines_oe_o, .sleep_status_o);

// File: sim/sram_ctrl_model.sv
// controller model driving the command, lane and data pins
`timescale 1ns/100ps
module sram_ctrl_model (
	// clock
	input  wire        clk_i,
	// command pins
	output reg         gate_n_o,
	output reg         cs1_n_o,
	output reg         cs2_o,
	output reg         cs3_n_o,
	output reg         adv_o,
	output reg         we_n_o,
	output reg  [3:0]  lanes_n_o,
	output reg  [5:0]  addr_o,
	// data, parity in the top four bits
	output reg  [35:0] bus_o
);
	reg [35:0] wd, d1, wc;
	reg        p1, dir, wn, en;
	initial
	begin
		{gate_n_o, cs1_n_o, cs2_o, cs3_n_o, adv_o, we_n_o} = 6'h15;
		lanes_n_o = 4'hF;
		addr_o = 6'h00;
		bus_o = 36'h0;
		{p1, dir} = 2'h0;
		wd = 36'h0;
	end
	task op(input [2:0] k, input [5:0] ad, input [3:0] ln, input [35:0] w);
	begin
		gate_n_o = (k == 3'h4);
		adv_o = (k == 3'h3);
		{cs1_n_o, cs2_o, cs3_n_o} = (k == 3'h1 || k == 3'h2) ? 3'h2 : 3'h5;
		we_n_o = (k == 3'h1);
		lanes_n_o = ln;
		addr_o = ad;
		wd = w;
		@(posedge clk_i);
		#1;
	end
	endtask
	// write data two edges after its command, else a moving pattern
	always @(posedge clk_i)
	begin
		en = !gate_n_o;
		wn = adv_o ? dir : (cs2_o && !we_n_o);
		wc = wd;
		#1;
		if (en)
		begin
			bus_o = p1 ? d1 : ~bus_o;
			p1 = wn;
			d1 = wc;
			dir = wn;
		end
	end
endmodule // sram_ctrl_model

// File: sim/tb_pipelined_burst_sram_port.sv
// self-checking bench for the pipelined burst sram port
`timescale 1ns/100ps
module tb_pipelined_burst_sram_port;
	localparam [2:0] DS = 3'h0, RD = 3'h1, WR = 3'h2, AV = 3'h3, ST = 3'h4;
	reg        clk = 1'b0;
	reg        rst_n = 1'b0;
	reg        oe_n = 1'b0;
	reg        sleep_req = 1'b0;
	reg        order = 1'b0;
	wire       gate_n, cs1_n, cs2, cs3_n, adv, we_n, slp;
	wire [3:0] lanes_n;
	wire [5:0] addr;
	wire [35:0] bus, rd, oe;
	reg [81:0] rows [0:3];
	reg [35:0] mem [0:15];
	reg [5:0]  a = 6'h00;
	reg [3:0]  l = 4'h0;
	reg [35:0] w = 36'h0, e;
	integer    errors = 0;
	integer    check_count = 0;
	integer    i, n;
	always #25 clk = ~clk;
	sram_ctrl_model u_sram_ctrl_model (.clk_i(clk), .gate_n_o(gate_n),
		.cs1_n_o(cs1_n), .cs2_o(cs2), .cs3_n_o(cs3_n), .adv_o(adv),
		.we_n_o(we_n), .lanes_n_o(lanes_n), .addr_o(addr), .bus_o(bus));
	pipelined_burst_sram_port #(.ADDR_W(6), .LANES(4))
	u_pipelined_burst_sram_port (.clk_i(clk), .rst_n_i(rst_n),
		.clock_gate_n_i(gate_n), .chip_select_first_n_i(cs1_n),
		.chip_select_second_i(cs2), .chip_select_third_n_i(cs3_n),
		.advance_or_load_i(adv), .write_n_i(we_n),
		.lane_write_select_n_i(lanes_n), .addr_i(addr),
		.output_drive_n_i(oe_n), .sleep_request_i(sleep_req),
		.burst_order_i(order), .dq_i(bus[31:0]), .dq_o(rd[31:0]),
		.dq_oe_o(oe[31:0]), .shared_parity_lines_i(bus[35:32]),
		.shared_parity_lines_o(rd[35:32]),
		.shared_parity_lines_oe_o(oe[35:32]), .sleep_status_o(slp));
	////////////////////////////////////////////////////////////////////////
	task go(input [2:0] k);
		u_sram_ctrl_model.op(k, a, l, w);
	endtask
	task chk(input [35:0] s, input [35:0] x);
	begin
		check_count = check_count + 1;
		if (s !== x)
		begin
			errors = errors + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	end
	endtask
	task close_out;
	begin
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task wait_slp(input v);
	begin
		for (n = 0; n < 20 && slp !== v; n = n + 1)
			go(DS);
		if (slp !== v)
		begin
			errors = errors + 1;
			close_out;
		end
	end
	endtask
	initial
	begin
		rows[0] = {6'h05, 4'h0, 36'h9_1234_5678, 36'h9_1234_5678};
		rows[1] = {6'h05, 4'hA, 36'h6_ABCD_EF01, 36'hC_12CD_5601};
		rows[2] = {6'h06, 4'h0, 36'h3_0F0F_0F0F, 36'h3_0F0F_0F0F};
		rows[3] = {6'h06, 4'hF, 36'hC_FFFF_0000, 36'h3_0F0F_0F0F};
		repeat (6) @(posedge clk);
		#1;
		chk(oe, 36'h0);
		rst_n = 1'b1;
		go(DS);
		chk(oe, 36'h0);
		for (i = 0; i < 4; i = i + 1)
		begin
			{a, l, w, e} = rows[i];
			go(WR);
			go(DS);
			go(RD);
			go(DS);
			chk(rd, e);
			chk(oe, 36'hF_FFFF_FFFF);
			oe_n = 1'b1;
			#1;
			chk(oe, 36'h0);
			oe_n = 1'b0;
			go(DS);
			chk(oe, 36'h0);
		end
		// read then write back to back
		{a, l, w} = {6'h05, 4'h0, 36'h7_0000_7777};
		go(RD);
		a = 6'h07;
		go(WR);
		chk(rd, 36'hC_12CD_5601);
		go(DS);
		chk(oe, 36'h0);
		go(DS);
		go(RD);
		go(DS);
		chk(rd, w);
		a = 6'h0B;
		for (n = 0; n < 4; n = n + 1)
		begin
			w = 36'hA_5A5A_0000 + n;
			mem[8 + (3 + n) % 4] = w;
			go((n > 0) ? AV : WR);
		end
		go(DS);
		go(DS);
		order = 1'b1;
		repeat (4) go(DS);
		a = 6'h09;
		go(RD);
		for (n = 0; n < 4; n = n + 1)
		begin
			// stall only after two advances, so the burst check sees them
			if (n == 2)
			begin
				go(ST);
				chk(rd, mem[8]);
			end
			go((n < 3) ? AV : DS);
			chk(rd, mem[8 + (1 ^ n)]);
		end
		sleep_req = 1'b1;
		wait_slp(1'b1);
		chk(oe, 36'h0);
		// hold the request long enough for the entry check
		repeat (2) go(DS);
		chk(oe, 36'h0);
		sleep_req = 1'b0;
		wait_slp(1'b0);
		repeat (3) go(DS);
		a = 6'h05;
		go(RD);
		go(DS);
		chk(rd, 36'hC_12CD_5601);
		close_out;
	end
endmodule // tb_pipelined_burst_sram_port
